/* core/vds_pkg.sv */
/*
 Constants, field layouts and carrier types for the shared voice and data
 control register bank. Assumes a 32-bit APB master and a byte address
 equal to four times the register index.
*/
package vds_pkg;
  localparam int AW = 16;
  // Register indices; the byte address is four times the index
  localparam logic [11:0] IX_VOLUME = 12'h001;
  localparam logic [11:0] IX_CTRL = 12'h400;
  localparam logic [11:0] IX_MAXRATE = 12'h42A;
  localparam logic [11:0] IX_TW2L = 12'h42E;
  localparam logic [11:0] IX_TW2H = 12'h42F;
  localparam logic [11:0] IX_TW3L = 12'h430;
  localparam logic [11:0] IX_TW3H = 12'h431;
  localparam logic [11:0] IX_RW2L = 12'h432;
  localparam logic [11:0] IX_RW2H = 12'h433;
  localparam logic [11:0] IX_RW3L = 12'h434;
  localparam logic [11:0] IX_RW3H = 12'h435;
  localparam logic [11:0] IX_ENABLE = 12'h439;
  localparam logic [11:0] IX_GAIN = 12'h990;
  localparam logic [11:0] IX_RXSTAT = 12'hA35;
  localparam logic [11:0] IX_T1AMP = 12'hAB0;
  localparam logic [11:0] IX_T2AMP = 12'hAB2;
  localparam logic [11:0] IX_T1FREQ = 12'hBB0;
  localparam logic [11:0] IX_T2FREQ = 12'hBB2;
  localparam logic [11:0] IX_MODE = 12'h0F0;
  localparam logic [11:0] IX_CONFIGURATION_CODE = 12'h0F1;
  // Field layouts
  localparam logic [7:0] CTRL_MASK = 8'hE6;
  localparam int CTRL_SQUELCH = 2;
  localparam int CTRL_SYMRATE = 1;
  localparam int CTRL_HANDSET = 5;
  localparam logic [7:0] MAXRATE_MASK = 8'h17;
  localparam int MAXRATE_SIL = 4;
  localparam logic [7:0] ENABLE_MASK = 8'h03;
  localparam int ENABLE_HOST = 1;
  localparam logic [7:0] VOLUME_MASK = 8'hC0;
  localparam int VOLUME_LSB = 6;
  localparam int MODE_NEW_CONFIGURATION_STROBE = 0;
  localparam int MODE_RETRAIN_REQUEST = 1;
  localparam int MODE_RATE_RENEGOTIATE_REQUEST = 2;
  localparam int MODE_ARC = 3;
  localparam int RXSTAT_DATA_ONLY = 14;
  // Rate sequence words: fixed bits and enable positions
  localparam logic [7:0] W2H_BASE = 8'h09;
  localparam logic [7:0] W2L_BASE = 8'h11;
  localparam logic [7:0] W3L_BASE = 8'h91;
  localparam logic [7:0] W2H_RST = 8'h0D;
  localparam logic [7:0] W2L_RST = 8'h11;
  localparam logic [7:0] W3L_RST = 8'h93;
  localparam logic [7:0] W3H_RST = 8'h01;
  localparam int W2H_4800 = 2;
  localparam int W2H_9600 = 1;
  localparam int W2L_7200 = 6;
  localparam int W2L_12000 = 5;
  localparam int W2L_14400 = 3;
  localparam int W3L_SIL = 1;
  localparam logic [15:0] GAIN_RST = 16'hF000;
  localparam logic [15:0] GAIN_MAX = 16'hFC00;
  localparam logic [1:0] VOL_TONE_CAL = 2'h2;

  typedef enum logic [2:0] {
    VDS_R4800, VDS_R7200, VDS_R9600, VDS_R12000, VDS_R14400
  } vds_rate_e;

  typedef struct packed {
    logic on;
    logic to_handset;
    logic to_speaker;
    logic amp_valid;
    logic [15:0] freq1;
    logic [15:0] freq2;
    logic [15:0] amp1;
    logic [15:0] amp2;
  } vds_tone_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] enable;
    logic [7:0] maxrate;
    logic [7:0] tw2l;
    logic [7:0] tw2h;
    logic [7:0] tw3l;
    logic [7:0] tw3h;
    logic [7:0] volume;
    logic [7:0] configuration_code;
    logic automatic_rate_negotiation;
    logic [15:0] gain;
    logic [15:0] t1amp;
    logic [15:0] t2amp;
    logic [15:0] t1freq;
    logic [15:0] t2freq;
  } vds_regs_s;
endpackage

/* core/vds_ctrl.sv */
/*
 Shared voice and data control bank: APB register slave, rate sequence
 builder, tone generator control and speaker settings.
 Assumes an APB master on i_clk; line status pins are asynchronous and
 are synchronised here; the rx rate words come from the modem pump on
 the same clock.
*/
`timescale 1ns/1ns
module vds_ctrl
  import vds_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_remote_onhook,
  input wire logic i_rx_data_only,
  input wire logic i_connected,
  input wire logic i_dtr,
  input wire logic [31:0] i_rx_rate_words,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic o_mute_to_remote,
  output logic o_voice_tx_en,
  output logic o_symbol_rate_3000,
  output logic o_silence_detect_en,
  output vds_rate_e o_vd_rate,
  output logic [7:0] o_data_only_cfg,
  output logic o_shared_mode,
  output logic o_auto_rate,
  output vds_tone_s o_tone,
  output logic o_spk_on,
  output logic [3:0] o_spk_atten_db,
  output logic [15:0] o_spk_gain,
  output logic o_spk_gain_active
);
  typedef struct packed {
    vds_regs_s regs;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic voice_en;
    logic sil_en;
    vds_rate_e vd_rate;
    logic [7:0] data_cfg;
    logic shared;
    vds_tone_s tone;
    logic spk_on;
    logic [3:0] spk_db;
    logic gain_act;
  } vds_state_s;

  vds_state_s s_ff;
  vds_state_s nxt_s;

  localparam vds_regs_s REGS_RST = '{
    ctrl: 8'h00, enable: 8'h00, maxrate: 8'h00,
    tw2l: W2L_RST, tw2h: W2H_RST, tw3l: W3L_RST, tw3h: W3H_RST,
    volume: 8'h00, configuration_code: 8'h00, automatic_rate_negotiation: 1'b0, gain: GAIN_RST,
    t1amp: 16'h0000, t2amp: 16'h0000, t1freq: 16'h0000, t2freq: 16'h0000};

  function automatic vds_rate_e rate_of(input logic [2:0] c);
    case (c)
      3'h3: rate_of = VDS_R7200;
      3'h4: rate_of = VDS_R9600;
      3'h5: rate_of = VDS_R12000;
      3'h6, 3'h7: rate_of = VDS_R14400;
      default: rate_of = VDS_R4800;
    endcase
  endfunction

  // Silence detection cannot be turned off at the lowest rate code
  function automatic logic sil_of(input logic [7:0] m);
    sil_of = m[MAXRATE_SIL] | (m[2:0] == 3'h0);
  endfunction

  // Word 2 enables every rate up to the chosen maximum
  function automatic logic [15:0] word2_of(input logic [2:0] c);
    logic [7:0] hi;
    logic [7:0] lo;
    vds_rate_e r;
    r = rate_of(c);
    hi = W2H_BASE;
    lo = W2L_BASE;
    hi[W2H_4800] = 1'b1;
    lo[W2L_7200] = (r >= VDS_R7200);
    hi[W2H_9600] = (r >= VDS_R9600);
    lo[W2L_12000] = (r >= VDS_R12000);
    lo[W2L_14400] = (r >= VDS_R14400);
    word2_of = {hi, lo};
  endfunction

  logic [11:0] idx;
  logic aligned;
  logic acc;
  logic wr;
  assign idx = i_paddr[13:2];
  assign aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[AW-1:14] == '0);
  assign acc = i_psel & i_penable & ~s_ff.pready;
  assign wr = i_psel & i_penable & i_pwrite & s_ff.pready & aligned;

  always_comb begin
    logic [31:0] rd;
    logic hit;
    logic new_configuration_strobe;
    logic retrain_request;
    logic rate_renegotiate_request;
    logic dtr;
    logic conn;
    logic [15:0] w2;
    rd = 32'h0000_0000;
    hit = 1'b1;
    new_configuration_strobe = 1'b0;
    retrain_request = 1'b0;
    rate_renegotiate_request = 1'b0;
    w2 = 16'h0000;
    dtr = s_ff.sy2[3];
    conn = s_ff.sy2[2];
    nxt_s = s_ff;
    nxt_s.sy1 = {i_dtr, i_connected, i_rx_data_only, i_remote_onhook};
    nxt_s.sy2 = s_ff.sy1;
    nxt_s.pready = acc;
    // Address decode, shared by read data and error answer
    if (idx == IX_VOLUME) begin
      rd[7:0] = s_ff.regs.volume;
    end else if (idx == IX_CTRL) begin
      rd[7:0] = s_ff.regs.ctrl;
    end else if (idx == IX_MAXRATE) begin
      rd[7:0] = s_ff.regs.maxrate;
    end else if (idx == IX_TW2L) begin
      rd[7:0] = s_ff.regs.tw2l;
    end else if (idx == IX_TW2H) begin
      rd[7:0] = s_ff.regs.tw2h;
    end else if (idx == IX_TW3L) begin
      rd[7:0] = s_ff.regs.tw3l;
    end else if (idx == IX_TW3H) begin
      rd[7:0] = s_ff.regs.tw3h;
    end else if (idx == IX_RW2L) begin
      rd[7:0] = i_rx_rate_words[7:0];
    end else if (idx == IX_RW2H) begin
      rd[7:0] = i_rx_rate_words[15:8];
    end else if (idx == IX_RW3L) begin
      rd[7:0] = i_rx_rate_words[23:16];
    end else if (idx == IX_RW3H) begin
      rd[7:0] = i_rx_rate_words[31:24];
    end else if (idx == IX_ENABLE) begin
      rd[7:0] = s_ff.regs.enable;
    end else if (idx == IX_GAIN) begin
      rd[15:0] = s_ff.regs.gain;
    end else if (idx == IX_RXSTAT) begin
      rd[RXSTAT_DATA_ONLY] = s_ff.sil_en & s_ff.sy2[1];
    end else if (idx == IX_T1AMP) begin
      rd[15:0] = s_ff.regs.t1amp;
    end else if (idx == IX_T2AMP) begin
      rd[15:0] = s_ff.regs.t2amp;
    end else if (idx == IX_T1FREQ) begin
      rd[15:0] = s_ff.regs.t1freq;
    end else if (idx == IX_T2FREQ) begin
      rd[15:0] = s_ff.regs.t2freq;
    end else if (idx == IX_MODE) begin
      rd[MODE_ARC] = s_ff.regs.automatic_rate_negotiation;
    end else if (idx == IX_CONFIGURATION_CODE) begin
      rd[7:0] = s_ff.regs.configuration_code;
    end else begin
      hit = 1'b0;
    end
    hit = hit & aligned;
    nxt_s.prdata = (acc && !i_pwrite && hit) ? rd : 32'h0000_0000;
    nxt_s.pslverr = acc & ~hit;
    if (wr) begin
      if (idx == IX_VOLUME) begin
        nxt_s.regs.volume = i_pwdata[7:0] & VOLUME_MASK;
      end else if (idx == IX_CTRL) begin
        nxt_s.regs.ctrl = i_pwdata[7:0] & CTRL_MASK;
      end else if (idx == IX_MAXRATE) begin
        nxt_s.regs.maxrate = i_pwdata[7:0] & MAXRATE_MASK;
      end else if (idx == IX_ENABLE) begin
        nxt_s.regs.enable = i_pwdata[7:0] & ENABLE_MASK;
      end else if (idx == IX_CONFIGURATION_CODE) begin
        nxt_s.regs.configuration_code = i_pwdata[7:0];
      end else if (idx == IX_MODE) begin
        nxt_s.regs.automatic_rate_negotiation = i_pwdata[MODE_ARC];
        new_configuration_strobe = i_pwdata[MODE_NEW_CONFIGURATION_STROBE];
        retrain_request = i_pwdata[MODE_RETRAIN_REQUEST];
        rate_renegotiate_request = i_pwdata[MODE_RATE_RENEGOTIATE_REQUEST];
      end else if (idx == IX_GAIN) begin
        // gain adjustable only while connected, capped
        if (conn) begin
          nxt_s.regs.gain = (i_pwdata[15:0] > GAIN_MAX) ?
            GAIN_MAX : i_pwdata[15:0];
        end
      end else if (idx == IX_T1AMP) begin
        nxt_s.regs.t1amp = i_pwdata[15:0];
      end else if (idx == IX_T2AMP) begin
        nxt_s.regs.t2amp = i_pwdata[15:0];
      end else if (idx == IX_T1FREQ) begin
        nxt_s.regs.t1freq = i_pwdata[15:0];
      end else if (idx == IX_T2FREQ) begin
        nxt_s.regs.t2freq = i_pwdata[15:0];
      end else if (dtr || s_ff.regs.maxrate == 8'h00) begin
        // zero max rate hands the masks to the host
        if (idx == IX_TW2L) begin
          nxt_s.regs.tw2l = i_pwdata[7:0];
        end else if (idx == IX_TW2H) begin
          nxt_s.regs.tw2h = i_pwdata[7:0];
        end else if (idx == IX_TW3L) begin
          nxt_s.regs.tw3l = i_pwdata[7:0];
        end else if (idx == IX_TW3H) begin
          nxt_s.regs.tw3h = i_pwdata[7:0];
        end
      end
    end
    // any strobe stops the tone generator
    if (new_configuration_strobe || retrain_request || rate_renegotiate_request) begin
      nxt_s.regs.t1amp = 16'h0000;
    end
    // new configuration rebuilds rate words 2 and 3
    // renegotiation applies a nonzero max rate
    if (new_configuration_strobe || (rate_renegotiate_request && s_ff.regs.maxrate != 8'h00)) begin
      w2 = word2_of(s_ff.regs.maxrate[2:0]);
      // word 2 enables from the rate field
      nxt_s.regs.tw2h = w2[15:8];
      nxt_s.regs.tw2l = w2[7:0];
      // word 3 carries the silence detection bit
      nxt_s.regs.tw3l = W3L_BASE;
      nxt_s.regs.tw3l[W3L_SIL] = sil_of(s_ff.regs.maxrate);
      nxt_s.regs.tw3h = W3H_RST;
      nxt_s.vd_rate = rate_of(s_ff.regs.maxrate[2:0]);
      nxt_s.sil_en = sil_of(s_ff.regs.maxrate);
    end
    if (new_configuration_strobe) begin
      nxt_s.shared = s_ff.regs.enable[ENABLE_HOST];
      nxt_s.data_cfg = s_ff.regs.configuration_code;
    end
    if (rate_renegotiate_request) begin
      // only the data-only rate follows the configuration
      nxt_s.data_cfg = s_ff.regs.configuration_code;
      nxt_s.regs.gain = GAIN_RST;
    end
    // tone runs in shared mode while the tone 1 amplitude is nonzero
    nxt_s.tone.on = s_ff.shared && (nxt_s.regs.t1amp != 16'h0000);
    // tones go to the selected earpiece path
    nxt_s.tone.to_handset = nxt_s.tone.on & nxt_s.regs.ctrl[CTRL_HANDSET];
    nxt_s.tone.to_speaker = nxt_s.tone.on & ~nxt_s.regs.ctrl[CTRL_HANDSET];
    // amplitude scale holds only at the calibration volume
    nxt_s.tone.amp_valid =
      nxt_s.regs.volume[VOLUME_LSB+:2] == VOL_TONE_CAL;
    // frequency and amplitude words pass unchanged to the pump
    nxt_s.tone.freq1 = nxt_s.regs.t1freq;
    nxt_s.tone.freq2 = nxt_s.regs.t2freq;
    nxt_s.tone.amp1 = nxt_s.regs.t1amp;
    nxt_s.tone.amp2 = nxt_s.regs.t2amp;
    nxt_s.voice_en = s_ff.shared & ~nxt_s.regs.ctrl[CTRL_SQUELCH] &
      ~nxt_s.tone.on;
    nxt_s.spk_on = nxt_s.regs.volume[VOLUME_LSB+:2] != 2'h0;
    case (nxt_s.regs.volume[VOLUME_LSB+:2])
      2'h2: nxt_s.spk_db = 4'h6;
      2'h3: nxt_s.spk_db = 4'hC;
      default: nxt_s.spk_db = 4'h0;
    endcase
    nxt_s.gain_act = conn;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_ff <= '{regs: REGS_RST, vd_rate: VDS_R4800, sil_en: 1'b1,
        default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_pready = s_ff.pready;
  assign o_prdata = s_ff.prdata;
  assign o_pslverr = s_ff.pslverr;
  // squelch is sent to the far end as on-hook
  assign o_mute_to_remote = s_ff.regs.ctrl[CTRL_SQUELCH];
  assign o_voice_tx_en = s_ff.voice_en;
  assign o_symbol_rate_3000 = s_ff.regs.ctrl[CTRL_SYMRATE];
  assign o_silence_detect_en = s_ff.sil_en;
  assign o_vd_rate = s_ff.vd_rate;
  assign o_data_only_cfg = s_ff.data_cfg;
  assign o_shared_mode = s_ff.shared;
  assign o_auto_rate = s_ff.regs.automatic_rate_negotiation;
  assign o_tone = s_ff.tone;
  assign o_spk_on = s_ff.spk_on;
  assign o_spk_atten_db = s_ff.spk_db;
  assign o_spk_gain = s_ff.regs.gain;
  assign o_spk_gain_active = s_ff.gain_act;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  logic wr_mode;
  assign wr_mode = wr && idx == IX_MODE;

  sequence s_apb_access;
    i_psel && i_penable && !o_pready ##1 i_psel && i_penable && o_pready;
  endsequence

  a_apb_one_wait: assert property (i_psel && !i_penable |=> s_apb_access)
    else $error("access phase not answered after one wait");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");
  a_squelch_mute: assert property (
    wr && idx == IX_CTRL && i_pwdata[CTRL_SQUELCH]
    |=> o_mute_to_remote && !o_voice_tx_en)
    else $error("squelch write did not mute voice");
  a_tone_suppress: assert property (o_tone.on |-> !o_voice_tx_en)
    else $error("voice carried while tone on");
  a_tone_strobe_stop: assert property (
    wr_mode && (i_pwdata[MODE_NEW_CONFIGURATION_STROBE] || i_pwdata[MODE_RETRAIN_REQUEST] ||
    i_pwdata[MODE_RATE_RENEGOTIATE_REQUEST]) |=> !o_tone.on ##1 !o_tone.on)
    else $error("tone not stopped by strobe");
  a_rate_decode: assert property (
    wr_mode && i_pwdata[MODE_NEW_CONFIGURATION_STROBE]
    |=> o_vd_rate == rate_of($past(s_ff.regs.maxrate[2:0])))
    else $error("voice+data rate decode wrong");
  a_word3_sil: assert property (
    wr_mode && i_pwdata[MODE_NEW_CONFIGURATION_STROBE]
    |=> s_ff.regs.tw3l[W3L_SIL] == $past(sil_of(s_ff.regs.maxrate)))
    else $error("word 3 silence bit wrong");
  a_reserved_zero: assert property (
    (s_ff.regs.ctrl & ~CTRL_MASK) == 8'h00 &&
    (s_ff.regs.maxrate & ~MAXRATE_MASK) == 8'h00)
    else $error("reserved bit set");
  a_gain_reset: assert property (
    wr_mode && i_pwdata[MODE_RATE_RENEGOTIATE_REQUEST] |=> o_spk_gain == GAIN_RST)
    else $error("gain not reset by renegotiation");
  a_gain_cap: assert property (o_spk_gain <= GAIN_MAX)
    else $error("gain above maximum");
  a_volume_low: assert property (
    s_ff.regs.volume[VOLUME_LSB+:2] == 2'h3 |-> o_spk_atten_db == 4'hC)
    else $error("volume decode wrong");
endmodule

/* bench/vds_partner.sv */
/*
 Far side of the control bank: remote modem and pump status lines.
 Assumes the bench asks for link up, DTR and data-only receive.
*/
`timescale 1ns/1ns
module vds_partner
  import vds_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_mute,
  input wire logic i_link_req,
  input wire logic i_dtr_req,
  input wire logic i_donly_req,
  output logic o_remote_onhook,
  output logic o_rx_data_only,
  output logic o_connected,
  output logic o_dtr,
  output logic [31:0] o_rx_rate_words
);
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_remote_onhook <= 1'b0;
      o_rx_data_only <= 1'b0;
      o_connected <= 1'b0;
      o_dtr <= 1'b0;
      o_rx_rate_words <= 32'h5A5A_A5A5;
    end else begin
      o_remote_onhook <= i_mute;
      o_connected <= i_link_req;
      o_dtr <= i_dtr_req;
      o_rx_data_only <= i_donly_req & i_link_req;
      // Off line the words mean nothing, so they never hold still
      o_rx_rate_words <= i_link_req ?
        {W3H_RST, W3L_RST, W2H_RST, W2L_RST} : ~o_rx_rate_words;
    end
  end
endmodule

/* bench/vds_ctrl_bench.sv */
/*
 Self-checking bench for the shared voice and data control bank.
 Assumes the package, the design and the far-side model compile first.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module vds_ctrl_bench;
  import vds_pkg::*;
  logic i_clk = 0, i_nrst = 0, psel = 0, pen = 0, pwr = 0;
  logic link_req = 0, dtr_req = 0, donly_req = 0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rxw;
  logic pready, pslverr, mute, voice_en, sym3000, sil, shared, automatic_rate_negotiation;
  logic spk_on, gact, onhook, donly, conn, dtr;
  logic [3:0] atten;
  logic [7:0] docfg;
  logic [15:0] gain;
  logic [32:0] e;
  vds_rate_e vrate;
  vds_tone_s tone;
  logic [32:0] expq[$];
  int num_errors = 0;
  int n_tests = 0;

  vds_ctrl dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_remote_onhook(onhook), .i_rx_data_only(donly), .i_connected(conn),
    .i_dtr(dtr), .i_rx_rate_words(rxw), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .o_mute_to_remote(mute),
    .o_voice_tx_en(voice_en), .o_symbol_rate_3000(sym3000),
    .o_silence_detect_en(sil), .o_vd_rate(vrate), .o_data_only_cfg(docfg),
    .o_shared_mode(shared), .o_auto_rate(automatic_rate_negotiation), .o_tone(tone),
    .o_spk_on(spk_on), .o_spk_atten_db(atten), .o_spk_gain(gain),
    .o_spk_gain_active(gact));

  vds_partner far (.i_clk(i_clk), .i_nrst(i_nrst), .i_mute(mute),
    .i_link_req(link_req), .i_dtr_req(dtr_req), .i_donly_req(donly_req),
    .o_remote_onhook(onhook), .o_rx_data_only(donly), .o_connected(conn),
    .o_dtr(dtr), .o_rx_rate_words(rxw));

  always #5 i_clk = ~i_clk;

  // Every completed transfer answers the oldest note
  always @(posedge i_clk) begin
    if (psel && pen && pready) begin
      e = (expq.size() > 0) ? expq.pop_front() : 33'h1_DEAD_BEEF;
      `CHK({pslverr, prdata}, e)
    end
  end

  task automatic close_out();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [11:0] ix,
                      input logic [31:0] d, input logic [32:0] x);
    int k;
    @(posedge i_clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= d;
    expq.push_back(x);
    @(posedge i_clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      close_out();
    end else begin
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] ix, input logic [31:0] d);
    xfer(1'b1, ix, d, 33'h0);
  endtask

  task automatic rd(input logic [11:0] ix, input logic [31:0] x);
    xfer(1'b0, ix, 32'h0, {1'b0, x});
  endtask

  // Far-side register, two sync stages plus the output register
  task automatic settle();
    repeat (4) @(posedge i_clk);
  endtask

  // host keeps the automatic rate bit set
  task automatic mode(input logic [3:0] b);
    wr(IX_MODE, {28'h0, b | 4'h8});
    settle();
  endtask

  function automatic logic [2:0] ridx(input logic [2:0] c);
    if (c < 3'h3) return 3'h0;
    if (c > 3'h5) return 3'h4;
    return c - 3'h2;
  endfunction

  initial begin
    logic [2:0] r;
    logic s, sx;
    logic [7:0] w2h, w2l;
    int v;
    void'($urandom(80));
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(IX_TW2L, 32'h11);
    rd(IX_TW2H, 32'h0D);
    rd(IX_TW3L, 32'h93);
    rd(IX_TW3H, 32'h01);
    rd(IX_GAIN, 32'hF000);
    wr(IX_CTRL, 32'hFF);
    rd(IX_CTRL, 32'hE6);
    settle();
    `CHK({mute, onhook, sym3000}, 3'h7)
    wr(IX_CTRL, 32'h0);
    settle();
    `CHK({mute, onhook, sym3000}, 3'h0)
    wr(IX_MAXRATE, 32'hFF);
    rd(IX_MAXRATE, 32'h17);
    xfer(1'b0, 12'h7FF, 32'h0, {1'b1, 32'h0});
    wr(IX_ENABLE, 32'h2);
    wr(IX_CONFIGURATION_CODE, 32'h76);
    for (v = 0; v < 8; v++) begin
      r = v[2:0];
      s = 1'($urandom);
      wr(IX_MAXRATE, {27'h0, s, 1'b0, r});
      mode(4'h1);
      sx = s | (r == 3'h0);
      w2h = 8'h0D | (ridx(r) > 1 ? 8'h02 : 8'h00);
      w2l = 8'h11 | (ridx(r) > 0 ? 8'h40 : 8'h00)
          | (ridx(r) > 2 ? 8'h20 : 8'h00) | (ridx(r) > 3 ? 8'h08 : 8'h00);
      `CHK(vrate, vds_rate_e'(ridx(r)))
      `CHK(sil, sx)
      rd(IX_TW2H, {24'h0, w2h});
      rd(IX_TW2L, {24'h0, w2l});
      rd(IX_TW3L, {24'h0, 8'h91 | {6'h0, sx, 1'b0}});
    end
    `CHK({shared, automatic_rate_negotiation}, 2'h3)
    wr(IX_T1FREQ, 32'h0C81);
    wr(IX_T2FREQ, 32'h0DA4);
    wr(IX_T2AMP, 32'h00CB);
    wr(IX_T1AMP, 32'h00CB);
    settle();
    `CHK({tone.on, tone.to_speaker, voice_en}, 3'h6)
    `CHK({tone.freq1, tone.freq2}, 32'h0C81_0DA4)
    `CHK(tone.amp2, 16'h00CB)
    wr(IX_T1AMP, 32'h0);
    settle();
    `CHK({tone.on, voice_en}, 2'h1)
    wr(IX_T1AMP, 32'h00CB);
    mode(4'h2);
    `CHK(tone.on, 1'b0)
    rd(IX_T1AMP, 32'h0);
    wr(IX_CTRL, 32'h04);
    settle();
    `CHK({mute, voice_en}, 2'h2)
    wr(IX_CTRL, 32'h20);
    wr(IX_T1AMP, 32'h0123);
    settle();
    `CHK({tone.to_handset, tone.to_speaker, tone.amp1}, 18'h2_0123)
    wr(IX_CTRL, 32'h0);
    wr(IX_T1AMP, 32'h0);
    for (v = 0; v < 4; v++) begin
      wr(IX_VOLUME, 32'(v << 6));
      settle();
      `CHK(spk_on, v != 0)
      if (v > 0) `CHK(atten, 4'((v - 1) * 6))
      `CHK(tone.amp_valid, v == 2)
    end
    wr(IX_GAIN, 32'hF200);
    rd(IX_GAIN, 32'hF000);
    link_req <= 1'b1;
    settle();
    wr(IX_GAIN, 32'hF200);
    rd(IX_GAIN, 32'hF200);
    settle();
    `CHK({gact, gain}, 17'h1_F200)
    wr(IX_GAIN, 32'hFE00);
    rd(IX_GAIN, 32'hFC00);
    mode(4'h4);
    rd(IX_GAIN, 32'hF000);
    wr(IX_TW2L, 32'h55);
    rd(IX_TW2L, 32'h79);
    dtr_req <= 1'b1;
    settle();
    wr(IX_TW2L, 32'h55);
    rd(IX_TW2L, 32'h55);
    dtr_req <= 1'b0;
    wr(IX_MAXRATE, 32'h0);
    settle();
    wr(IX_TW2H, 32'h0B);
    rd(IX_TW2H, 32'h0B);
    wr(IX_MAXRATE, 32'h4);
    wr(IX_CONFIGURATION_CODE, 32'hAA);
    mode(4'h4);
    `CHK({vrate, docfg}, {VDS_R9600, 8'hAA})
    wr(IX_CONFIGURATION_CODE, 32'h76);
    mode(4'h4);
    `CHK({vrate, docfg}, {VDS_R9600, 8'h76})
    wr(IX_MAXRATE, 32'h14);
    mode(4'h1);
    donly_req <= 1'b1;
    settle();
    rd(IX_RXSTAT, 32'h4000);
    donly_req <= 1'b0;
    settle();
    rd(IX_RXSTAT, 32'h0);
    wr(IX_RW2H, 32'hFF);
    rd(IX_RW2H, 32'h0D);
    close_out();
  end
endmodule
